// File: verilog/humidity_temp_measure_control.sv
/*
  Measurement command and result logic of an I2C slave sensor.
  SCL and SDA are open-drain, two signals each; inputs are synchronous
  to clk. Raw conversion results and threshold flags come from the
  analog front end as ports.
*/
`timescale 1ns/1ps

// Overview of operation
// - decode hold and no-hold temperature and humidity+temperature commands.
// - respond only to the single fixed 7-bit slave address.
// - in hold mode keep SCL low until the conversion result exists.
// - after releasing SCL, shift result bytes out on master clocks.
// - no-hold commands never stretch SCL.
// - read address after no-hold: ACK if done, NACK if converting.
// - two result bytes for temperature, four for humidity plus temperature.
// - words go out MSB first, upper byte first.
// - results are left-scaled to 14 bits regardless of resolution.
// - conversion time follows resolution and command type.
// - append CRC-8, poly 0x1d, init 0xff, no reflection, xorout 0.
// - CRC covers humidity then temperature words; humidity zero if absent.
// - in periodic mode a bare read between conversions returns the latest stored result.
// - in periodic mode ignore all commands except fetch and 0x30.
// - stop command leaves periodic mode and re-enables all commands.
// - periodic mode starts when enable bit 7 is written high.
// - alert high idle, low between and high during periodic conversions.
// - alert stays high when periodic mode is off.
// - in periodic mode, threshold mode drives alert from flags with programmed polarity.
// - with alerts enabled in periodic mode, send a status byte first.
// - status carries temp high, temp low, humid high, humid low flags.
module humidity_temp_measure_control
  import meas_pkg::*;
#(
  parameter int PERIOD_CYC = 10_000_000
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        scl_in,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_oe,
  input  wire logic [1:0]  temp_res,
  input  wire logic [1:0]  humid_res,
  input  wire logic        per_cfg_wr,
  input  wire logic [7:0]  per_cfg_data,
  input  wire logic        alert_thresh_en,
  input  wire logic        alert_polarity_low,
  input  wire logic        temp_high_flag,
  input  wire logic        temp_low_flag,
  input  wire logic        humid_high_flag,
  input  wire logic        humid_low_flag,
  input  wire logic [13:0] raw_humid,
  input  wire logic [13:0] raw_temp,
  output logic             alert,
  output logic             periodic_active,
  output logic             conv_busy
);
  initial
  begin
    if (PERIOD_CYC < 1)
      $error("PERIOD_CYC must be positive");
  end

  typedef enum {S_IDLE, S_ADDR, S_ACK_ADDR, S_CMD, S_ACK_CMD, S_TX, S_TX_ACK,
                S_STRETCH, S_IGNORE} i2c_state_t;

  // ------------------------------------------------------------
  // bus edge detection
  // ------------------------------------------------------------
  logic scl_d, sda_d;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_in;
      sda_d <= sda_in;
    end
  end
  assign scl_rise   = scl_in & ~scl_d;
  assign scl_fall   = ~scl_in & scl_d;
  assign start_cond = scl_in & scl_d & sda_d & ~sda_in;
  assign stop_cond  = scl_in & scl_d & ~sda_d & sda_in;

  // ------------------------------------------------------------
  // conversion engine
  // ------------------------------------------------------------
  logic        conv_start, conv_ht, conv_done_p, last_ht;
  logic        per_trig;
  logic [21:0] conv_cnt;
  logic [21:0] conv_len;
  logic        result_valid;
  logic [13:0] res_h, res_t;
  logic        crc_done;
  logic [7:0]  crc_val;

  function automatic logic [13:0] scale14(input logic [13:0] raw, input logic [1:0] res);
    // left-justify narrower conversions into the 14-bit field
    case (res)
      2'd0:    scale14 = {raw[7:0], 6'h00};
      2'd1:    scale14 = {raw[9:0], 4'h0};
      2'd2:    scale14 = {raw[11:0], 2'h0};
      default: scale14 = raw;
    endcase
  endfunction

  always_comb
  begin
    // length follows the running conversion, not the last decoded command
    if (last_ht)
      conv_len = 22'(us_to_cycles(HT_CONV_US[humid_res]));
    else
      conv_len = 22'(us_to_cycles(T_CONV_US[temp_res]));
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      conv_busy    <= 1'b0;
      conv_cnt     <= 22'h0;
      conv_done_p  <= 1'b0;
      result_valid <= 1'b0;
      last_ht      <= 1'b0;
      res_h        <= 14'h0;
      res_t        <= 14'h0;
    end
    else
    begin
      conv_done_p <= 1'b0;
      if ((conv_start || per_trig) && !conv_busy)
      begin
        conv_busy    <= 1'b1;
        conv_cnt     <= 22'h1;
        last_ht      <= conv_ht | per_trig;
        result_valid <= 1'b0;
      end
      else if (conv_busy)
      begin
        conv_cnt <= conv_cnt + 22'h1;
        if (conv_cnt >= conv_len)
        begin
          conv_busy   <= 1'b0;
          conv_done_p <= 1'b1;
          res_t       <= scale14(raw_temp, temp_res);
          res_h       <= last_ht ? scale14(raw_humid, humid_res) : 14'h0;
        end
      end
      if (crc_done)
        result_valid <= 1'b1;
    end
  end

  crc8_unit u_crc (
    .clk   (clk),
    .rst   (rst),
    .start (conv_done_p),
    .data  ({2'b00, res_h, 2'b00, res_t}),
    .done  (crc_done),
    .crc   (crc_val)
  );

  // ------------------------------------------------------------
  // periodic mode and alert
  // ------------------------------------------------------------
  logic [31:0] per_cnt;
  logic        stop_req;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      periodic_active <= 1'b0;
      per_cnt         <= 32'h0;
      per_trig        <= 1'b0;
    end
    else
    begin
      per_trig <= 1'b0;
      if (stop_req)
        periodic_active <= 1'b0;
      else if (per_cfg_wr && per_cfg_data[CFG_PER_EN_BIT])
        periodic_active <= 1'b1;
      if (!periodic_active || per_cnt >= 32'(PERIOD_CYC - 1))
      begin
        per_cnt  <= 32'h0;
        per_trig <= periodic_active;
      end
      else
        per_cnt <= per_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      alert <= 1'b1;
    else if (periodic_active && alert_thresh_en)
      alert <= (temp_high_flag | temp_low_flag | humid_high_flag | humid_low_flag)
               ^ alert_polarity_low;
    else if (periodic_active)
      alert <= conv_busy;
    else
      alert <= 1'b1;
  end

  // ------------------------------------------------------------
  // i2c slave
  // ------------------------------------------------------------
  i2c_state_t  state;
  logic [7:0]  shreg;
  logic [2:0]  bitc;
  logic        rw, hold_pend, do_ack;
  logic        bits_in;
  logic [2:0]  byte_idx, byte_cnt;
  logic [7:0]  tx_byte;
  logic        with_status;
  logic [7:0]  status;

  assign status = {temp_high_flag, temp_low_flag, humid_high_flag, humid_low_flag,
                   4'h0};

  always_comb
  begin
    // byte order: [status], [humid hi, lo], temp hi, lo, crc
    tx_byte = crc_val;
    case ({with_status, last_ht, byte_idx})
      5'b0_0_000, 5'b1_0_001:  tx_byte = {2'b00, res_t[13:8]};
      5'b0_0_001, 5'b1_0_010:  tx_byte = {res_t[7:0]};
      5'b0_1_000, 5'b1_1_001:  tx_byte = {2'b00, res_h[13:8]};
      5'b0_1_001, 5'b1_1_010:  tx_byte = res_h[7:0];
      5'b0_1_010, 5'b1_1_011:  tx_byte = {2'b00, res_t[13:8]};
      5'b0_1_011, 5'b1_1_100:  tx_byte = res_t[7:0];
      5'b1_0_000, 5'b1_1_000:  tx_byte = status;
      default:                 tx_byte = crc_val;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= S_IDLE; shreg <= 8'h0; bitc <= 3'h0; rw <= 1'b0;
      sda_oe <= 1'b0; scl_oe <= 1'b0; hold_pend <= 1'b0; do_ack <= 1'b0;
      byte_idx <= 3'h0; byte_cnt <= 3'h0; with_status <= 1'b0;
      conv_start <= 1'b0; conv_ht <= 1'b0; stop_req <= 1'b0;
      bits_in <= 1'b0;
    end
    else
    begin
      conv_start <= 1'b0;
      stop_req   <= 1'b0;
      if (stop_cond)
      begin
        state <= S_IDLE; sda_oe <= 1'b0; scl_oe <= 1'b0;
      end
      else if (start_cond)
      begin
        state <= S_ADDR; bitc <= 3'h0; sda_oe <= 1'b0;
        bits_in <= 1'b0;
      end
      else
        case (state)
          S_ADDR, S_CMD:
            if (scl_rise)
            begin
              shreg <= {shreg[6:0], sda_in};
              bitc  <= bitc + 3'h1;
              if (bitc == 3'h7)
                bits_in <= 1'b1;
            end
            // the scl fall right after a start carries no byte yet
            else if (scl_fall && bits_in)
            begin
              bits_in <= 1'b0;
              if (state == S_ADDR)
              begin
                rw <= shreg[0];
                do_ack <= (shreg[7:1] == SLAVE_ADDR);
                if (shreg[7:1] == SLAVE_ADDR && shreg[0] && hold_pend)
                begin
                  scl_oe <= 1'b1;
                  sda_oe <= 1'b1;
                  state  <= S_STRETCH;
                end
                else if (shreg[7:1] == SLAVE_ADDR && shreg[0] && !result_valid)
                  state <= S_IGNORE;
                else if (shreg[7:1] == SLAVE_ADDR)
                begin
                  sda_oe <= 1'b1;
                  state  <= S_ACK_ADDR;
                end
                else
                  state <= S_IGNORE;
              end
              else
              begin
                if (periodic_active)
                begin
                  if (shreg == CMD_STOP_PER)
                  begin
                    stop_req <= 1'b1;
                    sda_oe   <= 1'b1;
                    state    <= S_ACK_CMD;
                  end
                  else
                    state <= S_IGNORE;
                end
                else if (!conv_busy && (shreg == CMD_HOLD_T || shreg == CMD_NOHOLD_T ||
                         shreg == CMD_HOLD_HT || shreg == CMD_NOHOLD_HT))
                begin
                  conv_start <= 1'b1;
                  conv_ht    <= (shreg == CMD_HOLD_HT || shreg == CMD_NOHOLD_HT);
                  hold_pend  <= (shreg == CMD_HOLD_T || shreg == CMD_HOLD_HT);
                  sda_oe     <= 1'b1;
                  state      <= S_ACK_CMD;
                end
                else
                  state <= S_IGNORE;
              end
            end
          S_STRETCH:
            if (result_valid)
            begin
              scl_oe    <= 1'b0;
              hold_pend <= 1'b0;
              state     <= S_ACK_ADDR;
            end
          S_ACK_ADDR, S_ACK_CMD:
            if (scl_fall)
            begin
              sda_oe <= 1'b0;
              bitc   <= 3'h0;
              if (state == S_ACK_CMD)
                state <= S_CMD;
              else if (!rw)
                state <= S_CMD;
              else
              begin
                // fetch in periodic mode may carry status
                with_status <= periodic_active && alert_thresh_en;
                byte_cnt <= (last_ht ? 3'd5 : 3'd3) +
                            ((periodic_active && alert_thresh_en) ? 3'd1 : 3'd0);
                byte_idx <= 3'h0;
                state    <= S_TX;
                sda_oe   <= 1'b0;
              end
            end
          S_TX:
          begin
            sda_oe <= ~tx_byte[3'd7 - bitc];
            if (scl_fall)
            begin
              bitc <= bitc + 3'h1;
              if (bitc == 3'h7)
              begin
                state  <= S_TX_ACK;
                sda_oe <= 1'b0;
              end
            end
          end
          S_TX_ACK:
            if (scl_rise)
            begin
              byte_idx <= byte_idx + 3'h1;
              if (sda_in || byte_idx + 3'h1 == byte_cnt)
                state <= S_IGNORE;
            end
            // next byte only after scl falls, so sda never moves while scl is high
            else if (scl_fall)
            begin
              bitc  <= 3'h0;
              state <= S_TX;
            end
          default: sda_oe <= 1'b0;
        endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [21:0] busy_age;
  always_ff @(posedge clk)
  begin
    if (rst || !conv_busy)
      busy_age <= 22'h0;
    else
      busy_age <= busy_age + 22'h1;
  end

  a_stretch_until_ready: assert property (@(posedge clk) disable iff (rst)
    (scl_oe && !result_valid) |=> scl_oe) else $error("scl released early");
  a_nohold_no_stretch: assert property (@(posedge clk) disable iff (rst)
    (!hold_pend && state != S_STRETCH) |-> !scl_oe) else $error("scl held");
  a_alert_idle_high: assert property (@(posedge clk) disable iff (rst)
    !periodic_active |=> alert || periodic_active) else $error("alert low");
  a_alert_tracks_conv: assert property (@(posedge clk) disable iff (rst)
    (periodic_active && !alert_thresh_en) |=> alert == $past(conv_busy) || !periodic_active)
    else $error("alert mismatch");
  a_crc_after_conv: assert property (@(posedge clk) disable iff (rst)
    conv_done_p |-> ##33 crc_done) else $error("crc late");
  a_stop_leaves_per: assert property (@(posedge clk) disable iff (rst)
    stop_req |=> !periodic_active) else $error("periodic stuck");
  a_busy_no_restart: assert property (@(posedge clk) disable iff (rst)
    (conv_busy && conv_start) |=> $stable(last_ht)) else $error("restarted");
  a_conv_bounded: assert property (@(posedge clk) disable iff (rst)
    busy_age <= 22'(MAX_CONV_CYC)) else $error("conversion hung");
  a_status_low_zero: assert property (@(posedge clk) disable iff (rst)
    status[3:0] == 4'h0) else $error("status low bits");
  c_hold_meas: cover property (@(posedge clk) disable iff (rst) $fell(scl_oe));
  c_periodic: cover property (@(posedge clk) disable iff (rst) per_trig);
  c_fetch_status: cover property (@(posedge clk) disable iff (rst) state == S_TX && with_status);
endmodule

// File: shared/meas_pkg.sv
/*
  Shared constants for the measurement command and result logic:
  command codes, slave address, CRC settings, conversion times.
  Assumes a 20 MHz system clock.
*/
package meas_pkg;
  localparam int          CLK_HZ        = 20_000_000;
  localparam logic [6:0]  SLAVE_ADDR    = 7'h54;
  localparam logic [7:0]  CMD_HOLD_T    = 8'he3;
  localparam logic [7:0]  CMD_NOHOLD_T  = 8'hf3;
  localparam logic [7:0]  CMD_HOLD_HT   = 8'he5;
  localparam logic [7:0]  CMD_NOHOLD_HT = 8'hf5;
  localparam logic [7:0]  CMD_STOP_PER  = 8'h30;
  localparam logic [7:0]  CRC_POLY      = 8'h1d;
  localparam logic [7:0]  CRC_INIT      = 8'hff;
  localparam logic [7:0]  CRC_XOROUT    = 8'h00;
  localparam int          RES_WIDTH     = 14;
  localparam int          STAT_TH_BIT   = 7;
  localparam int          STAT_TL_BIT   = 6;
  localparam int          STAT_HH_BIT   = 5;
  localparam int          STAT_HL_BIT   = 4;
  localparam int          CFG_PER_EN_BIT = 7;
  // conversion times in microseconds, index = resolution code 0..3
  localparam int          T_CONV_US [4] = '{370, 450, 600, 910};
  localparam int          HT_CONV_US[4] = '{640, 800, 1040, 1700};
  // shortest time rounds up to one cycle
  function automatic int us_to_cycles(input int us);
    return (us * (CLK_HZ / 1_000_000) < 1) ? 1 : us * (CLK_HZ / 1_000_000);
  endfunction
  localparam int          MAX_CONV_CYC  = 1700 * (CLK_HZ / 1_000_000);
endpackage

// File: verilog/crc8_unit.sv
/*
  Serial CRC-8 over a 32-bit word, one bit per cycle, MSB first.
  Assumes start is a single-cycle pulse while idle.
*/
`timescale 1ns/1ps
module crc8_unit
  import meas_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [31:0] data,
  output logic             done,
  output logic [7:0]       crc
);
  logic [31:0] shreg;
  logic [5:0]  cnt;
  logic        busy;
  logic        fb;

  assign fb = crc[7] ^ shreg[31];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      crc  <= 8'h00;
      cnt  <= 6'h00;
      shreg <= 32'h0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        busy  <= 1'b1;
        crc   <= CRC_INIT;
        shreg <= data;
        cnt   <= 6'h00;
      end
      else if (busy)
      begin
        crc   <= {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        shreg <= {shreg[30:0], 1'b0};
        cnt   <= cnt + 6'h01;
        if (cnt == 6'h1f)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// File: bench/i2c_master_model.sv
/*
  Bus master model that faces the measurement block over SCL and SDA.
  Assumes the bench resolves both open-drain lines with pull-ups and
  calls these tasks from one process; signals move at falling clk edges.
*/
`timescale 1ns/1ps
module i2c_master_model
#(
  parameter int HALF = 25
)
(
  input  wire logic        clk,
  input  wire logic        scl,
  input  wire logic        sda,
  output logic             scl_oe,
  output logic             sda_oe,
  output logic             stuck,
  output logic [31:0]      stretch
);
  initial
  begin
    scl_oe  = 1'b0;
    sda_oe  = 1'b0;
    stuck   = 1'b0;
    stretch = 32'h0000_0000;
  end

  task automatic half_bit();
    repeat (HALF) @(negedge clk);
  endtask

  // a held-low scl is waited out under a bound; total hold time is summed
  task automatic bit_io(input logic b, output logic r);
    int n;
    n = 0;
    sda_oe <= !b;
    half_bit();
    scl_oe <= 1'b0;
    @(negedge clk);
    while (scl !== 1'b1 && n < 40000)
    begin
      @(negedge clk);
      n++;
    end
    stuck   <= stuck | (n == 40000);
    stretch <= stretch + 32'(n);
    half_bit();
    r = sda;
    scl_oe <= 1'b1;
  endtask

  // also serves as repeated start when scl is low
  task automatic start_cond();
    sda_oe <= 1'b0;
    half_bit();
    scl_oe <= 1'b0;
    half_bit();
    sda_oe <= 1'b1;
    half_bit();
    scl_oe <= 1'b1;
  endtask

  task automatic stop_cond();
    sda_oe <= 1'b1;
    half_bit();
    scl_oe <= 1'b0;
    half_bit();
    sda_oe <= 1'b0;
    half_bit();
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule

// File: bench/testbench.sv
/*
  Self-checking bench: hold, no-hold and periodic flows driven through
  the bus master model. Assumes a shortened periodic interval.
*/
`timescale 1ns/1ps
module testbench
  import meas_pkg::*;
;
  localparam int PER = 16000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        scl_oe, sda_oe, m_scl_oe, m_sda_oe, stuck;
  logic [31:0] stretch;
  wire logic   scl = !(scl_oe | m_scl_oe);
  wire logic   sda = !(sda_oe | m_sda_oe);
  logic [1:0]  temp_res = 2'h0;
  logic [1:0]  humid_res = 2'h0;
  logic        per_cfg_wr = 1'b0;
  logic [7:0]  per_cfg_data = 8'h00;
  logic        thr_en = 1'b0;
  logic        pol_low = 1'b0;
  logic        th = 1'b0;
  logic        tl = 1'b0;
  logic        hh = 1'b0;
  logic        hl = 1'b0;
  // 8-bit codes that scale up to 0x0580 at the lowest resolution
  logic [13:0] raw_humid = 14'h0016;
  logic [13:0] raw_temp = 14'h0016;
  logic        alert, periodic_active, conv_busy, a;
  logic [7:0]  b;
  int          mismatches = 0;
  int          comparisons = 0;

  always #25 clk = ~clk;

  humidity_temp_measure_control #(.PERIOD_CYC(PER)) u_humidity_temp_measure_control (
    .clk(clk), .rst(rst), .scl_in(scl), .scl_oe(scl_oe), .sda_in(sda), .sda_oe(sda_oe),
    .temp_res(temp_res), .humid_res(humid_res), .per_cfg_wr(per_cfg_wr),
    .per_cfg_data(per_cfg_data), .alert_thresh_en(thr_en), .alert_polarity_low(pol_low),
    .temp_high_flag(th), .temp_low_flag(tl), .humid_high_flag(hh), .humid_low_flag(hl),
    .raw_humid(raw_humid), .raw_temp(raw_temp), .alert(alert),
    .periodic_active(periodic_active), .conv_busy(conv_busy));

  i2c_master_model u_i2c_master_model (
    .clk(clk), .scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe),
    .stuck(stuck), .stretch(stretch));

  // ---------------------------------------------
  // checking and closing
  // ---------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge stuck)
  begin
    mismatches++;
    results();
  end

  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 31; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1d : 8'h00);
    return c;
  endfunction

  // ---------------------------------------------
  // bus helpers
  // ---------------------------------------------
  task automatic addr(input logic [7:0] ab, input logic exp);
    u_i2c_master_model.start_cond();
    u_i2c_master_model.wr_byte(ab, a);
    check(8'(a), 8'(exp));
  endtask

  task automatic command(input logic [7:0] c, input logic exp);
    addr({SLAVE_ADDR, 1'b0}, 1'b1);
    u_i2c_master_model.wr_byte(c, a);
    check(8'(a), 8'(exp));
  endtask

  // the last byte gets the master's not-acknowledge
  task automatic read_all(input logic [7:0] exp [$]);
    foreach (exp[i])
    begin
      u_i2c_master_model.rd_byte(i != exp.size() - 1, b);
      check(b, exp[i]);
    end
    u_i2c_master_model.stop_cond();
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (conv_busy !== lvl && n < 40000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 40000)
    begin
      mismatches++;
      results();
    end
    repeat (3) @(negedge clk);
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic sc_reset_and_addr();
    check(8'(alert), 8'h01);
    check({periodic_active, conv_busy, scl_oe, sda_oe}, 8'h00);
    addr({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b0);
    u_i2c_master_model.stop_cond();
  endtask

  task automatic sc_hold_temp();
    logic [31:0] s0;
    command(CMD_HOLD_T, 1'b1);
    s0 = stretch;
    addr({SLAVE_ADDR, 1'b1}, 1'b1);
    check(8'(stretch - s0 >= 6500 && stretch - s0 <= 7500), 8'h01);
    read_all('{8'h05, 8'h80, crc8(32'h0000_0580)});
  endtask

  task automatic sc_nohold_ht();
    logic [31:0] s0;
    s0 = stretch;
    command(CMD_NOHOLD_HT, 1'b1);
    u_i2c_master_model.stop_cond();
    addr({SLAVE_ADDR, 1'b1}, 1'b0);
    u_i2c_master_model.stop_cond();
    command(CMD_HOLD_T, 1'b0);
    u_i2c_master_model.stop_cond();
    check(8'(stretch === s0), 8'h01);
    // retry once the conversion time has surely run out
    repeat (13000) @(negedge clk);
    addr({SLAVE_ADDR, 1'b1}, 1'b1);
    read_all('{8'h05, 8'h80, 8'h05, 8'h80, 8'hf2});
  endtask

  task automatic sc_periodic();
    per_cfg_data = 8'h80;
    per_cfg_wr = 1'b1;
    @(negedge clk);
    per_cfg_wr = 1'b0;
    @(negedge clk);
    check(8'(periodic_active), 8'h01);
    wait_busy(1'b1);
    check(8'(alert), 8'h01);
    wait_busy(1'b0);
    check(8'(alert), 8'h00);
    addr({SLAVE_ADDR, 1'b1}, 1'b1);
    read_all('{8'h05, 8'h80, 8'h05, 8'h80, 8'hf2});
    command(CMD_NOHOLD_T, 1'b0);
    u_i2c_master_model.stop_cond();
    thr_en = 1'b1;
    th = 1'b1;
    hl = 1'b1;
    repeat (3) @(negedge clk);
    check(8'(alert), 8'h01);
    pol_low = 1'b1;
    repeat (3) @(negedge clk);
    check(8'(alert), 8'h00);
    // a periodic conversion may be running; fetch once it is stored
    wait_busy(1'b1);
    wait_busy(1'b0);
    addr({SLAVE_ADDR, 1'b1}, 1'b1);
    read_all('{8'h90, 8'h05, 8'h80, 8'h05, 8'h80, 8'hf2});
    thr_en = 1'b0;
    pol_low = 1'b0;
    command(CMD_STOP_PER, 1'b1);
    u_i2c_master_model.stop_cond();
    repeat (3) @(negedge clk);
    check({periodic_active, alert}, 8'h01);
    wait_busy(1'b0);
    command(CMD_NOHOLD_T, 1'b1);
    u_i2c_master_model.stop_cond();
  endtask

  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    sc_reset_and_addr();
    sc_hold_temp();
    sc_nohold_ht();
    sc_periodic();
    results();
  end
endmodule
